// ==== rtl/epil_latch.sv ====
// external pin interrupt latch with status/control register port
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps

// Operation
// R1: a low on the interrupt pin latches a request.
// R2: vector fetch of this interrupt clears the latch.
// R3: writing one to the latch-clear strobe clears the latch.
// R4: reset clears latch and trigger-select even with pin low.
// R5: falling edges always trigger; trigger-select adds low-level sensitivity.
// R6: edge-only: request holds until fetch, software clear or reset.
// R7: edge-and-level: clears only after acknowledge and pin high, any order.
// R8: edge-and-level: request stays pending while pin is low.
// R9: set request mask blocks forwarding to priority logic.
// R10: cpu global interrupt mask also blocks this request.
// R11: falling edge after software clear latches a new request.
// R12: taken request loads pc from vector pair fffa/fffb.
// R13: pending flag ignores the request mask.
// R14: software should mask level requests inside its service routine.
// R15: software may clear the latch before leaving its service routine.
// R16: with break-clear enable set, break-state clear works and sticks.
// R17: with break-clear enable clear, break-state clear does nothing.
// R18: latch-clear strobe is write-only, reads zero, reset clear.
// R19: trigger-select one is edge plus level, zero edge only.
// R20: writing one to mask disables requests; reset clears mask.
// R21: pending flag is read-only, reads one while request pending.
// R22: pin is synchronised and falling edge found against previous sample.
module epil_latch
    import epil_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        irq_pin_n,
    input  wire logic        vector_fetch,
    input  wire logic        cpu_int_mask,
    input  wire logic        break_state,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             irq_to_cpu,
    output logic      [15:0] vector_addr
);

    logic       pin_meta_ff;
    logic       pin_sync_ff;
    logic       pin_prev_ff;
    logic       latch_ff;
    logic       ack_seen_ff;
    logic       trig_sel_ff;
    logic       req_mask_ff;
    logic       brk_clr_en_ff;
    logic [7:0] rdata_ff;
    logic       fall_edge;
    logic       wr_status;
    logic       sw_clear;
    logic       ack;
    logic       level_hold;
    logic       pending;
    logic       nxt_latch;
    logic       nxt_ack_seen;

    // two-stage synchroniser; first stage read only by the second and by a_sync_edge.
    // no reset: the chain keeps tracking the pin during reset, so a pin
    // held low across reset is not mistaken for a fresh falling edge
    always_ff @(posedge clk_sys)
    begin
        pin_meta_ff <= irq_pin_n;
        pin_sync_ff <= pin_meta_ff;
        pin_prev_ff <= pin_sync_ff;
    end

    assign fall_edge = pin_prev_ff & ~pin_sync_ff; // see R22
    assign wr_status = reg_wr && (reg_addr == ADDR_STATUS_CTRL);
    // break state ignores the software clear unless enabled
    assign sw_clear  = wr_status && reg_wdata[BIT_LATCH_CLR] // see R3
                       && (!break_state || brk_clr_en_ff); // see R16 see R17
    assign ack       = vector_fetch || sw_clear; // see R2 see R3
    assign level_hold = (trig_sel_ff == EPIL_EDGE_LEVEL) && !pin_sync_ff;

    // latch logic: a new edge wins over a clear in the same cycle
    always_comb
    begin
        nxt_latch    = latch_ff;
        nxt_ack_seen = ack_seen_ff;
        if (trig_sel_ff == EPIL_EDGE_ONLY)
        begin
            nxt_ack_seen = 1'b0;
            if (ack)
                nxt_latch = 1'b0; // see R6
        end
        else
        begin
            if (ack)
                nxt_ack_seen = 1'b1;
            // both acknowledge and pin high needed, either order
            if ((ack || ack_seen_ff) && pin_sync_ff)
            begin
                nxt_latch    = 1'b0; // see R7
                nxt_ack_seen = 1'b0;
            end
        end
        if (fall_edge)
        begin
            nxt_latch    = 1'b1; // see R1 see R5 see R11
            nxt_ack_seen = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            latch_ff    <= RST_LATCH; // see R4
            ack_seen_ff <= 1'b0;
        end
        else
        begin
            latch_ff    <= nxt_latch;
            ack_seen_ff <= nxt_ack_seen;
        end
    end

    // in edge-and-level mode pending also covers a held-low level so the request stays up while the pin is low
    assign pending = latch_ff || level_hold; // see R8

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            trig_sel_ff <= RST_TRIG_SEL; // see R4 see R19
            req_mask_ff <= RST_REQ_MASK; // see R20
        end
        else if (wr_status)
        begin
            trig_sel_ff <= reg_wdata[BIT_TRIG_SEL]; // see R19
            req_mask_ff <= reg_wdata[BIT_REQ_MASK]; // see R20
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            brk_clr_en_ff <= RST_BRK_CLR_EN;
        else if (reg_wr && (reg_addr == ADDR_BREAK_CTRL))
            brk_clr_en_ff <= reg_wdata[BIT_BRK_CLR_EN];
    end

    // read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rdata_ff <= 8'h00;
        else if (reg_rd)
        begin
            rdata_ff <= 8'h00;
            if (reg_addr == ADDR_STATUS_CTRL)
            begin
                rdata_ff[BIT_TRIG_SEL]  <= trig_sel_ff;
                rdata_ff[BIT_REQ_MASK]  <= req_mask_ff;
                rdata_ff[BIT_LATCH_CLR] <= 1'b0; // see R18
                rdata_ff[BIT_PENDING]   <= pending; // see R13 see R21
            end
            else if (reg_addr == ADDR_BREAK_CTRL)
                rdata_ff[BIT_BRK_CLR_EN] <= brk_clr_en_ff;
        end
        else
            rdata_ff <= 8'h00;
    end

    assign reg_rdata = rdata_ff;

    // the cpu global mask gates this request like every other source
    assign irq_to_cpu  = pending && !req_mask_ff // see R9
                         && !cpu_int_mask; // see R10
    assign vector_addr = VEC_ADDR_HI; // see R12

    a_edge_latches: assert property ( // see R1
        @(posedge clk_sys) disable iff (sys_rst)
        fall_edge |=> pending)
        else $error("falling edge did not latch a request");

    a_edge_only_sens: assert property ( // see R5
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_sel_ff == EPIL_EDGE_ONLY) |-> (pending == latch_ff))
        else $error("edge-only mode reported a level request");

    a_fetch_clears: assert property ( // see R2
        @(posedge clk_sys) disable iff (sys_rst)
        (vector_fetch && !fall_edge && trig_sel_ff == EPIL_EDGE_ONLY)
        |=> !latch_ff)
        else $error("vector fetch did not clear edge latch");

    a_sw_clear: assert property ( // see R3
        @(posedge clk_sys) disable iff (sys_rst)
        (sw_clear && !fall_edge && trig_sel_ff == EPIL_EDGE_ONLY)
        |=> !latch_ff)
        else $error("software clear did not clear latch");

    a_edge_holds: assert property ( // see R6
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_sel_ff == EPIL_EDGE_ONLY && latch_ff && !ack) |=> latch_ff)
        else $error("edge latch dropped without acknowledge");

    a_level_clears: assert property ( // see R7
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_sel_ff == EPIL_EDGE_LEVEL && (ack || ack_seen_ff)
         && pin_sync_ff) |=> !latch_ff)
        else $error("level latch stuck after acknowledge and pin high");

    a_level_holds: assert property ( // see R8
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_sel_ff == EPIL_EDGE_LEVEL && !pin_sync_ff) |-> pending)
        else $error("level request dropped while pin low");

    a_level_needs_both: assert property ( // see R7
        @(posedge clk_sys) disable iff (sys_rst)
        (trig_sel_ff == EPIL_EDGE_LEVEL && latch_ff && !pin_sync_ff
         && !ack_seen_ff && !ack) |=> latch_ff)
        else $error("level latch cleared without acknowledge");

    a_mask_blocks: assert property ( // see R9
        @(posedge clk_sys) disable iff (sys_rst)
        (req_mask_ff || cpu_int_mask) |-> !irq_to_cpu)
        else $error("masked request reached the cpu");

    a_unmasked_fwd: assert property ( // see R9
        @(posedge clk_sys) disable iff (sys_rst)
        (pending && !req_mask_ff && !cpu_int_mask) |-> irq_to_cpu)
        else $error("unmasked pending request not forwarded");

    a_cpu_mask: assert property ( // see R10
        @(posedge clk_sys) disable iff (sys_rst)
        (cpu_int_mask && pending) |-> !irq_to_cpu)
        else $error("global mask did not block the request");

    a_edge_sets_latch: assert property ( // see R11
        @(posedge clk_sys) disable iff (sys_rst)
        fall_edge |=> latch_ff)
        else $error("falling edge lost against an acknowledge");

    a_pend_masked: assert property ( // see R13
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_STATUS_CTRL && req_mask_ff && pending)
        |=> reg_rdata[BIT_PENDING])
        else $error("masked pending request hidden from the flag");

    a_pend_reads: assert property ( // see R21
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_rd && reg_addr == ADDR_STATUS_CTRL)
        |=> (reg_rdata[BIT_PENDING] == $past(pending)))
        else $error("pending flag read back wrong");

    a_break_protect: assert property ( // see R17
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_status && reg_wdata[BIT_LATCH_CLR] && break_state
         && !brk_clr_en_ff && !vector_fetch && latch_ff) |=> latch_ff)
        else $error("break-state clear altered the latch");

    a_break_clear: assert property ( // see R16
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_status && reg_wdata[BIT_LATCH_CLR] && break_state
         && brk_clr_en_ff && trig_sel_ff == EPIL_EDGE_ONLY && !fall_edge)
        |=> !latch_ff)
        else $error("enabled break-state clear left the latch set");

    a_reset_clears: assert property ( // see R4
        @(posedge clk_sys)
        sys_rst |=> (!latch_ff && !trig_sel_ff && !req_mask_ff))
        else $error("reset left latch or controls set");

    a_read_strobe0: assert property ( // see R18
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |-> !reg_rdata[BIT_LATCH_CLR])
        else $error("latch-clear strobe read back as one");

    a_trig_write: assert property ( // see R19
        @(posedge clk_sys) disable iff (sys_rst)
        wr_status |=> (trig_sel_ff == $past(reg_wdata[BIT_TRIG_SEL])))
        else $error("trigger select did not take the written value");

    a_mask_write: assert property ( // see R20
        @(posedge clk_sys) disable iff (sys_rst)
        wr_status |=> (req_mask_ff == $past(reg_wdata[BIT_REQ_MASK])))
        else $error("request mask did not take the written value");

    a_sync_edge: assert property ( // see R22
        @(posedge clk_sys) disable iff (sys_rst)
        (pin_sync_ff && !pin_meta_ff) |=> fall_edge)
        else $error("synchronised falling edge not detected");

    a_rdata_idle: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !reg_rd |=> (reg_rdata == 8'h00))
        else $error("read data stood outside its read cycle");

    c_edge_req:  cover property (@(posedge clk_sys) fall_edge ##1 irq_to_cpu);
    c_level_any: cover property (@(posedge clk_sys)
        trig_sel_ff && ack && !pin_sync_ff ##[1:20] !latch_ff);
    c_break_clr: cover property (@(posedge clk_sys)
        sw_clear && break_state);
    c_masked:    cover property (@(posedge clk_sys) pending && req_mask_ff);
    c_fetch_clr: cover property (@(posedge clk_sys)
        vector_fetch && latch_ff ##1 !latch_ff);

endmodule : epil_latch

// ==== shared/epil_pkg.sv ====
// package for the external pin interrupt latch: register map and constants
package epil_pkg;

    // register index/byte offset of the status/control word
    localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
    // break flag control register (break_clear_enable in bit 0)
    localparam logic [3:0] ADDR_BREAK_CTRL  = 4'h4;

    // field positions of pin_interrupt_status_control
    localparam int BIT_TRIG_SEL    = 0;
    localparam int BIT_REQ_MASK    = 1;
    localparam int BIT_LATCH_CLR   = 2;
    localparam int BIT_PENDING     = 3;
    // field position in break_flag_control_register
    localparam int BIT_BRK_CLR_EN  = 0;

    // reset values
    localparam logic RST_TRIG_SEL   = 1'b0;
    localparam logic RST_REQ_MASK   = 1'b0;
    localparam logic RST_BRK_CLR_EN = 1'b0;
    localparam logic RST_LATCH      = 1'b0;

    // vector pair fetched for this request
    localparam logic [15:0] VEC_ADDR_HI = 16'hfffa;
    localparam logic [15:0] VEC_ADDR_LO = 16'hfffb;

    // sensitivity selected by the trigger-select bit
    typedef enum logic [0:0]
    {
        EPIL_EDGE_ONLY  = 1'b0,
        EPIL_EDGE_LEVEL = 1'b1
    } epil_trig_t;

endpackage : epil_pkg

// ==== sim/epil_pin_src.sv ====
// pin source model driving the low-active interrupt pin
`timescale 1ns/100ps
module epil_pin_src
(
    input  wire logic clk_sys,
    input  wire logic pull_low,
    output logic      irq_pin_n
);
    // a released pin rises to the internal pull-up level
    always_ff @(posedge clk_sys)
    begin
        irq_pin_n <= ~pull_low;
    end
endmodule : epil_pin_src

// ==== sim/epil_latch_test.sv ====
// self-checking bench for the external pin interrupt latch
`timescale 1ns/100ps
module epil_latch_test;
    import epil_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        pull_low = 1'b0;
    logic        irq_pin_n;
    logic        vector_fetch = 1'b0;
    logic        cpu_int_mask = 1'b0;
    logic        break_state = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        irq_to_cpu;
    logic [15:0] vector_addr;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [7:0]  v;
    always #2 clk_sys = ~clk_sys;
    epil_pin_src u_src (.clk_sys(clk_sys), .pull_low(pull_low),
        .irq_pin_n(irq_pin_n));
    epil_latch DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .irq_pin_n(irq_pin_n), .vector_fetch(vector_fetch),
        .cpu_int_mask(cpu_int_mask), .break_state(break_state),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_to_cpu(irq_to_cpu),
        .vector_addr(vector_addr));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [15:0] s,
                       input logic [15:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [7:0] st(input logic p, m, t);
        return {4'h0, p, 1'b0, m, t};
    endfunction : st
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk("rdata", {8'h00, reg_rdata}, {8'h00, e});
    endtask : rd
    // pin path is partner flop plus two synchroniser flops plus latch
    task automatic drive(input logic l);
        @(posedge clk_sys);
        pull_low <= l;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask : drive
    task automatic fetch();
        @(posedge clk_sys);
        vector_fetch <= 1'b1;
        @(posedge clk_sys);
        vector_fetch <= 1'b0;
    endtask : fetch
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        v = 8'($urandom(32'h11c4ed2f));
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(ADDR_STATUS_CTRL, st(0, 0, 0));
        rd(ADDR_BREAK_CTRL, 8'h00);
        rd(4'h9, 8'h00);
        chk("vector", vector_addr, VEC_ADDR_HI);
        drive(1'b1);
        chk("irq", {15'h0, irq_to_cpu}, 16'h1);
        drive(1'b0);
        rd(ADDR_STATUS_CTRL, st(1, 0, 0));
        wr(ADDR_STATUS_CTRL, 8'h04);
        rd(ADDR_STATUS_CTRL, st(0, 0, 0));
        drive(1'b1);
        rd(ADDR_STATUS_CTRL, st(1, 0, 0));
        fetch();
        rd(ADDR_STATUS_CTRL, st(0, 0, 0));
        drive(1'b0);
        wr(ADDR_STATUS_CTRL, 8'h02);
        drive(1'b1);
        rd(ADDR_STATUS_CTRL, st(1, 1, 0));
        chk("irq", {15'h0, irq_to_cpu}, 16'h0);
        wr(ADDR_STATUS_CTRL, 8'h00);
        cpu_int_mask <= 1'b1;
        #1 chk("irq", {15'h0, irq_to_cpu}, 16'h0);
        @(posedge clk_sys);
        cpu_int_mask <= 1'b0;
        #1 chk("irq", {15'h0, irq_to_cpu}, 16'h1);
        wr(ADDR_STATUS_CTRL, 8'h04);
        drive(1'b0);
        // level service: mask inside the routine to avoid repeats
        wr(ADDR_STATUS_CTRL, 8'h03);
        drive(1'b1);
        wr(ADDR_STATUS_CTRL, 8'h07);
        rd(ADDR_STATUS_CTRL, st(1, 1, 1));
        drive(1'b0);
        rd(ADDR_STATUS_CTRL, st(0, 1, 1));
        drive(1'b1);
        drive(1'b0);
        rd(ADDR_STATUS_CTRL, st(1, 1, 1));
        fetch();
        rd(ADDR_STATUS_CTRL, st(0, 1, 1));
        wr(ADDR_STATUS_CTRL, 8'h00);
        drive(1'b1);
        @(posedge clk_sys);
        break_state <= 1'b1;
        wr(ADDR_STATUS_CTRL, 8'h04);
        rd(ADDR_STATUS_CTRL, st(1, 0, 0));
        wr(ADDR_BREAK_CTRL, 8'h01);
        rd(ADDR_BREAK_CTRL, 8'h01);
        wr(ADDR_STATUS_CTRL, 8'h04);
        break_state <= 1'b0;
        rd(ADDR_STATUS_CTRL, st(0, 0, 0));
        drive(1'b0);
        repeat (6)
        begin
            v = 8'($urandom());
            wr(ADDR_STATUS_CTRL, {6'h00, v[1:0]});
            rd(ADDR_STATUS_CTRL, st(0, v[1], v[0]));
        end
        wr(ADDR_STATUS_CTRL, 8'h01);
        drive(1'b1);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("irq", {15'h0, irq_to_cpu}, 16'h0);
        // pin held low across reset must not look like a new edge
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        drive(1'b1);
        rd(ADDR_STATUS_CTRL, st(0, 0, 0));
        drive(1'b0);
        drive(1'b1);
        rd(ADDR_STATUS_CTRL, st(1, 0, 0));
        end_of_test();
    end
endmodule : epil_latch_test
